// ==== design/recovery_params.svh ====
// constants for the stop, halt and recovery control block
`ifndef RECOVERY_PARAMS_SVH
`define RECOVERY_PARAMS_SVH
// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS 50
`define POR_TIME_NS 4000000
`define POR_TIME_MS 4
`define POR_CNT_W 17
`define WDT_CNT_W 14
`define LOCK_LAST 7'h7F
`define PRE_LAST 4'hF
`define RESTART_VEC 16'h000C
// ****************************************************************
// register map, byte offsets within the slave
// ****************************************************************
`define ADDR_SRC 4'h0
`define ADDR_WDM 4'h4
`define ADDR_CMD 4'h8
`define ADDR_CFG 4'hC
`define SRC_RESET 8'h20
`define WDM_RESET 5'h0D
// ****************************************************************
// field positions
// ****************************************************************
`define SRC_WARM 7
`define SRC_LEVEL 6
`define SRC_DELAY 5
`define SRC_SEL_HI 4
`define SRC_SEL_LO 2
`define SRC_DIV1 1
`define SRC_DIV16 0
`define WDM_TIME_HI 1
`define WDM_TIME_LO 0
`define WDM_HALT 2
`define WDM_STOP 3
`define WDM_XTAL 4
`define CMD_HALT 0
`define CMD_STOP 1
`define CMD_WDT 2
`define CFG_ANALOG 0
// ****************************************************************
// wake source codes and watchdog periods
// ****************************************************************
`define SEL_A 3'h2
`define SEL_B 3'h3
`define SEL_C 3'h4
`define SEL_P27 3'h5
`define SEL_NOR4 3'h6
`define SEL_NOR8 3'h7
`define WDT_X0 14'h0200
`define WDT_X1 14'h0400
`define WDT_X2 14'h0800
`define WDT_X3 14'h2000
`define WDT_MS0 10
`define WDT_MS1 20
`define WDT_MS2 40
`define WDT_MS3 160
`endif

// ==== design/recovery_pkg.sv ====
// types shared by the stop, halt and recovery control block
`include "recovery_params.svh"
package recovery_pkg;
  typedef enum logic [2:0] {MODE_POR, MODE_RUN, MODE_HALT, MODE_STOP, MODE_RECOVER} pwr_mode_t;

  typedef struct packed {
    logic power_ok;
    logic rc_osc;
    logic wake_input_a;
    logic wake_input_b;
    logic wake_input_c;
    logic [7:0] port2;
  } pin_in_t;

  typedef struct packed {
    pwr_mode_t mode;
    logic [7:0] stop_recovery_control;
    logic [4:0] watchdog_mode_control;
    logic analog;
    logic wdt_on;
    logic [`WDT_CNT_W-1:0] wdt_cnt;
    logic [`POR_CNT_W-1:0] por_cnt;
    logic [6:0] lock_cnt;
    logic half;
    logic [3:0] pre_cnt;
    logic rc_prev;
    logic bus_wr;
    logic addr_ok;
    logic [3:0] addr;
    logic [31:0] rdata;
    logic rst_out;
    logic sys_en;
    logic tim_en;
  } ctl_state_t;
endpackage

// ==== design/pin_sync.sv ====
// three-stage synchroniser; output follows once stages two and three agree
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 13
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } sync_state_t;

  sync_state_t r;
  sync_state_t n;
  logic [WIDTH-1:0] agree;

  // per bit, a change counts only when the two late stages agree
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_agree
    assign agree[i] = r.s2[i] == r.s3[i];
  end

  always_comb
  begin
    n = r;
    n.s1 = async_i;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.q = (r.q & ~agree) | (r.s2 & agree);
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      r <= '0;
    else
      r <= n;
  end

  assign sync_o = r.q;
endmodule

// ==== design/stop_halt_recovery_control.sv ====
// low-power mode, reset delay, clock divider and watchdog control with an AHB-Lite slave
// Function
// - power-ok, delayed recovery or watchdog start delay
// - power-on delay lasts at least 4 ms
// - bit 5 selects delay after stop recovery
// - halt stops cpu clock, timers keep running
// - halt ends on serviced interrupt, power fail or watchdog expiry
// - stop kills both clocks, resets restart 000CH
// - watchdog bits 3,4 keep crystal during stop
// - bit 7 warm flag, set entering stop
// - other bits write-only, read shows flag only
// - bit 6 selects wake level, default low
// - bits 4-2 select the wake source
// - analog port-3 inputs never wake
// - bit 1 selects crystal divide by one, bypassing the divide by two
// - bit 0 divide-by-16, cleared by resets
// - delay timer clocked by rc or crystal
// - watchdog retriggerable one-shot, first instruction enables
// - stop recovery keeps mode registers intact
//
// Design decisions made here: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
`include "recovery_params.svh"
module stop_halt_recovery_control #(
  parameter logic [`POR_CNT_W-1:0] POR_CYCLES = `POR_CNT_W'((`POR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS),
  parameter int RC_KHZ = 32
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic [31:0] hrdata_o,
  output logic hresp_o,
  input wire recovery_pkg::pin_in_t pins_i,
  input wire logic irq_service_i,
  output logic cpu_clk_en_o,
  output logic timer_clk_en_o,
  output logic xtal_en_o,
  output logic cpu_reset_o,
  output logic [15:0] restart_addr_o,
  output logic halt_o,
  output logic stop_o
);
  // ****************************************************************
  // state and constants
  // ****************************************************************
  localparam recovery_pkg::ctl_state_t ST_RESET = '{
    mode: recovery_pkg::MODE_POR,
    stop_recovery_control: `SRC_RESET,
    watchdog_mode_control: `WDM_RESET,
    rst_out: 1'b1,
    default: '0
  };
  localparam logic [`POR_CNT_W-1:0] POR_RC = `POR_CNT_W'(`POR_TIME_MS * RC_KHZ);

  recovery_pkg::ctl_state_t r;
  recovery_pkg::ctl_state_t n;
  recovery_pkg::pin_in_t sy;
  logic rc_edge;
  logic tick;
  logic acc;
  logic wr_src;
  logic wr_wdm;
  logic wr_cmd;
  logic wr_cfg;
  logic cmd_halt;
  logic cmd_stop;
  logic cmd_wdt;
  logic [2:0] sel;
  logic raw;
  logic wake_hit;
  logic pre;
  logic clk_tick;
  logic wdt_run;
  logic wdt_timeout;
  logic [`WDT_CNT_W-1:0] wdt_limit;
  logic [`POR_CNT_W-1:0] por_target;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  pin_sync #(
    .WIDTH($bits(recovery_pkg::pin_in_t))
  ) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .async_i(pins_i),
    .sync_o(sy)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    n = r;
    n.rc_prev = sy.rc_osc;
    rc_edge = sy.rc_osc & ~r.rc_prev;
    tick = r.watchdog_mode_control[`WDM_XTAL] | rc_edge;
    por_target = r.watchdog_mode_control[`WDM_XTAL] ? POR_CYCLES : POR_RC;
    case (r.watchdog_mode_control[`WDM_TIME_HI:`WDM_TIME_LO])
      2'h0: wdt_limit = r.watchdog_mode_control[`WDM_XTAL] ? `WDT_X0 : `WDT_CNT_W'(`WDT_MS0 * RC_KHZ);
      2'h1: wdt_limit = r.watchdog_mode_control[`WDM_XTAL] ? `WDT_X1 : `WDT_CNT_W'(`WDT_MS1 * RC_KHZ);
      2'h2: wdt_limit = r.watchdog_mode_control[`WDM_XTAL] ? `WDT_X2 : `WDT_CNT_W'(`WDT_MS2 * RC_KHZ);
      default: wdt_limit = r.watchdog_mode_control[`WDM_XTAL] ? `WDT_X3 : `WDT_CNT_W'(`WDT_MS3 * RC_KHZ);
    endcase

    // bus: zero wait states, read data registered in the address phase
    acc = hsel_i & htrans_i[1] & hready_i;
    n.bus_wr = acc & hwrite_i;
    n.addr_ok = haddr_i[31:4] == 28'h0000000;
    n.addr = haddr_i[3:0];
    n.rdata = '0;
    if (acc && !hwrite_i && n.addr_ok)
    begin
      case (haddr_i[3:0])
        `ADDR_SRC: n.rdata[`SRC_WARM] = r.stop_recovery_control[`SRC_WARM];
        `ADDR_CMD: n.rdata[2:0] = r.mode;
        `ADDR_CFG: n.rdata[`CFG_ANALOG] = r.analog;
        default: n.rdata = '0;
      endcase
    end
    wr_src = r.bus_wr && r.addr_ok && r.addr == `ADDR_SRC;
    wr_wdm = r.bus_wr && r.addr_ok && r.addr == `ADDR_WDM;
    wr_cmd = r.bus_wr && r.addr_ok && r.addr == `ADDR_CMD;
    wr_cfg = r.bus_wr && r.addr_ok && r.addr == `ADDR_CFG;
    cmd_halt = wr_cmd && hwdata_i[`CMD_HALT] && r.mode == recovery_pkg::MODE_RUN;
    cmd_stop = wr_cmd && hwdata_i[`CMD_STOP] && r.mode == recovery_pkg::MODE_RUN && !cmd_halt;
    cmd_wdt = wr_cmd && hwdata_i[`CMD_WDT] && r.mode == recovery_pkg::MODE_RUN;
    if (wr_src)
      n.stop_recovery_control[6:0] = hwdata_i[6:0];
    if (wr_wdm && r.lock_cnt != `LOCK_LAST)
      n.watchdog_mode_control = hwdata_i[4:0];
    if (wr_cfg)
      n.analog = hwdata_i[`CFG_ANALOG];

    // wake source and level, on synchronised pins only
    sel = r.stop_recovery_control[`SRC_SEL_HI:`SRC_SEL_LO];
    case (sel)
      `SEL_A: raw = sy.wake_input_a;
      `SEL_B: raw = sy.wake_input_b;
      `SEL_C: raw = sy.wake_input_c;
      `SEL_P27: raw = sy.port2[7];
      `SEL_NOR4: raw = ~|sy.port2[3:0];
      `SEL_NOR8: raw = ~|sy.port2;
      default: raw = 1'b0;
    endcase
    wake_hit = r.mode == recovery_pkg::MODE_STOP && sel >= `SEL_A &&
               !(r.analog && sel <= `SEL_C) &&
               raw == r.stop_recovery_control[`SRC_LEVEL];

    // clock divider; sys rate limit of the divide-by-one path is the user's concern
    n.half = ~r.half;
    pre = r.stop_recovery_control[`SRC_DIV1] | r.half;
    if (pre)
      n.pre_cnt = r.pre_cnt + 4'h1;
    clk_tick = r.stop_recovery_control[`SRC_DIV16] ? (pre && r.pre_cnt == `PRE_LAST) : pre;

    // watchdog one-shot
    wdt_run = r.wdt_on && (r.mode == recovery_pkg::MODE_RUN ||
              (r.mode == recovery_pkg::MODE_HALT && r.watchdog_mode_control[`WDM_HALT]) ||
              (r.mode == recovery_pkg::MODE_STOP && r.watchdog_mode_control[`WDM_STOP]));
    wdt_timeout = wdt_run && tick && r.wdt_cnt == wdt_limit - `WDT_CNT_W'(1);
    if (cmd_wdt)
    begin
      n.wdt_on = 1'b1;
      n.wdt_cnt = '0;
    end
    else if (wdt_run && tick)
      n.wdt_cnt = r.wdt_cnt + `WDT_CNT_W'(1);

    if (r.mode == recovery_pkg::MODE_RUN && r.lock_cnt != `LOCK_LAST)
      n.lock_cnt = r.lock_cnt + 7'h01;

    // mode sequencing
    n.rst_out = 1'b0;
    case (r.mode)
      recovery_pkg::MODE_POR:
      begin
        n.rst_out = 1'b1;
        if (tick)
          n.por_cnt = r.por_cnt + `POR_CNT_W'(1);
        if (tick && r.por_cnt >= por_target - `POR_CNT_W'(1))
        begin
          n.mode = recovery_pkg::MODE_RUN;
          n.rst_out = 1'b0;
        end
      end
      recovery_pkg::MODE_RUN:
      begin
        if (cmd_halt)
          n.mode = recovery_pkg::MODE_HALT;
        else if (cmd_stop)
        begin
          n.mode = recovery_pkg::MODE_STOP;
          n.stop_recovery_control[`SRC_WARM] = 1'b1;
        end
      end
      recovery_pkg::MODE_HALT:
        if (irq_service_i)
          n.mode = recovery_pkg::MODE_RUN;
      recovery_pkg::MODE_STOP:
      begin
        if (wake_hit)
        begin
          n.stop_recovery_control[`SRC_DIV16] = 1'b0;
          n.lock_cnt = '0;
          n.wdt_on = 1'b0;
          n.wdt_cnt = '0;
          n.rst_out = 1'b1;
          n.por_cnt = '0;
          n.mode = r.stop_recovery_control[`SRC_DELAY] ? recovery_pkg::MODE_POR : recovery_pkg::MODE_RECOVER;
        end
      end
      recovery_pkg::MODE_RECOVER:
        n.mode = recovery_pkg::MODE_RUN;
      default:
        n.mode = recovery_pkg::MODE_POR;
    endcase

    // enables follow the next mode, so no cpu pulse leaks into a first halt or stop cycle
    n.sys_en = clk_tick && n.mode == recovery_pkg::MODE_RUN;
    n.tim_en = clk_tick && (n.mode == recovery_pkg::MODE_RUN || n.mode == recovery_pkg::MODE_HALT);

    // power fail and watchdog expiry restore every register default except rc_prev and half
    if (!sy.power_ok || wdt_timeout)
    begin
      n = ST_RESET;
      n.rc_prev = sy.rc_osc;
      n.half = ~r.half;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      r <= ST_RESET;
    else
      r <= n;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = r.rdata;
  assign cpu_clk_en_o = r.sys_en;
  assign timer_clk_en_o = r.tim_en;
  assign cpu_reset_o = r.rst_out;
  assign restart_addr_o = `RESTART_VEC;
  assign halt_o = r.mode == recovery_pkg::MODE_HALT;
  assign stop_o = r.mode == recovery_pkg::MODE_STOP;
  // crystal stays up in stop only for a watchdog run from it
  assign xtal_en_o = r.mode != recovery_pkg::MODE_STOP ||
                     (r.watchdog_mode_control[`WDM_STOP] && r.watchdog_mode_control[`WDM_XTAL]);

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  chk_timeout_delay: assert property (wdt_timeout |=> cpu_reset_o && r.mode == recovery_pkg::MODE_POR)
    else $error("watchdog expiry did not start the delay");
  chk_delay_length: assert property ($past(r.mode) == recovery_pkg::MODE_POR && r.mode == recovery_pkg::MODE_RUN
    |-> $past(r.por_cnt) >= $past(por_target) - `POR_CNT_W'(1))
    else $error("delay ended early");
  chk_stop_bypass: assert property (wake_hit && sy.power_ok && !wdt_timeout && !r.stop_recovery_control[`SRC_DELAY]
    |=> r.mode == recovery_pkg::MODE_RECOVER && cpu_reset_o ##1 r.mode == recovery_pkg::MODE_RUN)
    else $error("bypassed recovery wrong");
  chk_halt_clocks: assert property (r.mode == recovery_pkg::MODE_HALT |-> !cpu_clk_en_o && xtal_en_o)
    else $error("halt clocks wrong");
  chk_stop_clocks: assert property (stop_o |-> !cpu_clk_en_o && !timer_clk_en_o)
    else $error("clock enables live in stop");
  chk_halt_hold: assert property (r.mode == recovery_pkg::MODE_HALT && !irq_service_i && sy.power_ok && !wdt_timeout
    |=> r.mode == recovery_pkg::MODE_HALT)
    else $error("halt left without interrupt");
  chk_stop_xtal: assert property (stop_o |-> xtal_en_o ==
    (r.watchdog_mode_control[`WDM_STOP] && r.watchdog_mode_control[`WDM_XTAL]))
    else $error("stop crystal gate wrong");
  chk_warm_flag: assert property (cmd_stop && sy.power_ok && !wdt_timeout
    |=> stop_o && r.stop_recovery_control[`SRC_WARM])
    else $error("warm flag not set");
  chk_read_mask: assert property (acc && !hwrite_i && haddr_i == 32'h00000000
    |=> hrdata_o[6:0] == 7'h00 && hrdata_o[31:8] == 24'h000000)
    else $error("write-only bits visible");
  chk_div_clear: assert property (wake_hit |=> !r.stop_recovery_control[`SRC_DIV16])
    else $error("divide-by-16 not cleared");
  chk_mode_keep: assert property (wake_hit && sy.power_ok && !wdt_timeout
    |=> $stable(r.watchdog_mode_control) && $stable(r.stop_recovery_control[6:1]))
    else $error("recovery disturbed mode registers");

  cov_halt_exit: cover property (halt_o ##1 r.mode == recovery_pkg::MODE_RUN);
  cov_stop_delay: cover property (wake_hit ##1 r.mode == recovery_pkg::MODE_POR);
  cov_stop_fast: cover property (wake_hit ##1 r.mode == recovery_pkg::MODE_RECOVER);
  cov_wdt_expiry: cover property (wdt_timeout);
  cov_stop_xtal: cover property (stop_o && xtal_en_o);
endmodule

// ==== verif/pin_partner.sv ====
// pin-side model: supply flag, rc oscillator, wake inputs and port 2
`timescale 1ns/100ps
module pin_partner (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [12:0] drive_i,
  output recovery_pkg::pin_in_t pins_o
);
  logic [1:0] rc_div_r;
  // ****************************************************************
  // rc oscillator
  // ****************************************************************
  // free running like the real cell: one rising edge every four clocks
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      rc_div_r <= 2'h0;
    else
      rc_div_r <= rc_div_r + 2'h1;
  end
  assign pins_o = recovery_pkg::pin_in_t'({drive_i[12], rc_div_r[1], drive_i[10:0]});
endmodule

// ==== verif/test_stop_halt_recovery_control.sv ====
// self-checking bench for the stop, halt and recovery control block
`timescale 1ns/100ps
`include "recovery_params.svh"
module test_stop_halt_recovery_control;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic irq = 1'b0;
  // power_ok, unused rc slot, wake a/b/c, port2
  logic [12:0] drive = 13'h1FFF;
  logic hready, hresp, cpu_en, tim_en, xtal, cpu_rst, halt, stop;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [15:0] restart;
  recovery_pkg::pin_in_t pins;
  int errors = 0;
  int checks_done = 0;
  int cpu_cnt, tim_cnt;

  always #25 clock_i = ~clock_i;

  pin_partner partner (.clock_i(clock_i), .rst_i(rst_i), .drive_i(drive), .pins_o(pins));

  stop_halt_recovery_control #(.POR_CYCLES(17'h14), .RC_KHZ(2)) DUT (
    .clock_i(clock_i), .rst_i(rst_i), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hrdata_o(hrdata), .hresp_o(hresp), .pins_i(pins),
    .irq_service_i(irq), .cpu_clk_en_o(cpu_en), .timer_clk_en_o(tim_en), .xtal_en_o(xtal),
    .cpu_reset_o(cpu_rst), .restart_addr_o(restart), .halt_o(halt), .stop_o(stop));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clock_i);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        errors++;
        complete_run();
      end
      @(posedge clock_i);
    end
  endtask

  // one single word transfer: address phase, then data phase
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clock_i);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // bounded wait for one output (0 reset, 1 stop, 2 halt) to reach a level
  task automatic wait_for(input int which, input logic v, input int bound);
    logic s;
    for (int i = 0; i < bound; i++)
    begin
      @(posedge clock_i);
      #1;
      s = (which == 0) ? cpu_rst : (which == 1) ? stop : halt;
      if (s === v)
        return;
    end
    errors++;
    complete_run();
  endtask

  // counts cpu and timer enable pulses over a number of settled cycles
  task automatic count_en(input int cycles);
    cpu_cnt = 0;
    tim_cnt = 0;
    repeat (cycles)
    begin
      @(posedge clock_i);
      #1;
      cpu_cnt += int'(cpu_en === 1'b1);
      tim_cnt += int'(tim_en === 1'b1);
    end
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial
  begin
    repeat (5) @(posedge clock_i);
    #1;
    check(cpu_rst, 1'b1);
    check(hready, 1'b1);
    check(xtal, 1'b1);
    check(restart, `RESTART_VEC);
    check(hresp, 1'b0);
    @(posedge clock_i);
    rst_i <= 1'b0;
    // eight rc edges take 32 clocks, so 28 is still inside the delay
    repeat (28) @(posedge clock_i);
    #1;
    check(cpu_rst, 1'b1);
    wait_for(0, 1'b0, 500);
    rd_chk(32'h0, 32'h0);
    rd_chk(32'h8, 32'h1);
    // halt: cpu clock stops, timers and crystal go on
    xfer(1'b1, 32'h8, 32'h1);
    wait_for(2, 1'b1, 5);
    count_en(16);
    check(cpu_cnt, 0);
    check(tim_cnt, 8);
    check(xtal, 1'b1);
    check(halt, 1'b1);
    @(posedge clock_i);
    irq <= 1'b1;
    @(posedge clock_i);
    irq <= 1'b0;
    wait_for(2, 1'b0, 10);
    rd_chk(32'h8, 32'h1);
    // stop, wake on input a low, no delay; analog mode masks it first
    xfer(1'b1, 32'h0, 32'h08);
    xfer(1'b1, 32'hC, 32'h1);
    xfer(1'b1, 32'h8, 32'h2);
    wait_for(1, 1'b1, 5);
    check(xtal, 1'b0);
    check(cpu_en, 1'b0);
    rd_chk(32'h0, 32'h80);
    @(posedge clock_i);
    drive[10] <= 1'b0;
    repeat (20) @(posedge clock_i);
    #1;
    check(stop, 1'b1);
    xfer(1'b1, 32'hC, 32'h0);
    wait_for(1, 1'b0, 20);
    check(cpu_rst, 1'b1);
    wait_for(0, 1'b0, 5);
    rd_chk(32'h8, 32'h1);
    rd_chk(32'h0, 32'h80);
    @(posedge clock_i);
    drive[10] <= 1'b1;
    // stop, wake on nor of port 2 at high level, with the reset delay
    xfer(1'b1, 32'h0, 32'h7D);
    xfer(1'b1, 32'h8, 32'h2);
    wait_for(1, 1'b1, 5);
    @(posedge clock_i);
    drive[7:0] <= 8'h00;
    wait_for(1, 1'b0, 20);
    #1;
    check(cpu_rst, 1'b1);
    repeat (20) @(posedge clock_i);
    #1;
    check(cpu_rst, 1'b1);
    wait_for(0, 1'b0, 500);
    @(posedge clock_i);
    drive[7:0] <= 8'hFF;
    rd_chk(32'h8, 32'h1);
    // watchdog: 40 rc edges, restarted before they run out
    xfer(1'b1, 32'h8, 32'h4);
    repeat (100) @(posedge clock_i);
    xfer(1'b1, 32'h8, 32'h4);
    repeat (100) @(posedge clock_i);
    #1;
    check(cpu_rst, 1'b0);
    wait_for(0, 1'b1, 400);
    rd_chk(32'h0, 32'h0);
    wait_for(0, 1'b0, 500);
    // supply loss and return
    @(posedge clock_i);
    drive[12] <= 1'b0;
    wait_for(0, 1'b1, 20);
    @(posedge clock_i);
    drive[12] <= 1'b1;
    wait_for(0, 1'b0, 500);
    // crystal kept in stop, delay then counted in crystal clocks
    xfer(1'b1, 32'h4, 32'h1D);
    xfer(1'b1, 32'h0, 32'h28);
    xfer(1'b1, 32'h8, 32'h2);
    wait_for(1, 1'b1, 5);
    check(xtal, 1'b1);
    @(posedge clock_i);
    drive[10] <= 1'b0;
    wait_for(1, 1'b0, 20);
    check(cpu_rst, 1'b1);
    repeat (18) @(posedge clock_i);
    #1;
    check(cpu_rst, 1'b1);
    wait_for(0, 1'b0, 5);
    @(posedge clock_i);
    drive[10] <= 1'b1;
    rd_chk(32'h0, 32'h80);
    // divide by two then by 16: one pulse per 32 clocks; undivided: every clock
    xfer(1'b1, 32'h0, 32'h21);
    count_en(64);
    check(cpu_cnt, 2);
    check(tim_cnt, 2);
    xfer(1'b1, 32'h0, 32'h22);
    count_en(64);
    check(cpu_cnt, 64);
    check(tim_cnt, 64);
    // unmapped place and write-only watchdog mode register
    xfer(1'b1, 32'h10, 32'hFF);
    rd_chk(32'h10, 32'h0);
    rd_chk(32'h4, 32'h0);
    complete_run();
  end
endmodule
